/* File: rtl/dcce_pkg.sv */
// Package for the DAC correction engine: register map, fields, defaults, timing.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package dcce_pkg;

  localparam int          NUM_CH          = 8;
  localparam int          CODE_W          = 12;
  localparam int          CLK_MHZ         = 25;
  localparam int          CORR_TIME_NS    = 500;
  localparam int          CORR_CYCLES     = (CORR_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [4:0]  CORR_LAST       = 5'(CORR_CYCLES - 1);

  // Byte addresses
  localparam logic [11:0] ADDR_CONFIG     = 12'h000;
  localparam logic [11:0] ADDR_BUSY       = 12'h004;
  localparam logic [11:0] ADDR_SHIFT_A    = 12'h008;
  localparam logic [11:0] ADDR_SHIFT_B    = 12'h00c;
  localparam logic [11:0] ADDR_INPUT0     = 12'h100;
  localparam logic [11:0] ADDR_GAIN0      = 12'h120;
  localparam logic [11:0] ADDR_ZERO0      = 12'h140;
  localparam logic [11:0] ADDR_DACDATA0   = 12'h160;

  // Configuration fields
  localparam int          CFG_ENABLE_BIT  = 0;
  localparam int          CFG_GAIN_BIT    = 1;
  localparam int          CFG_ACTIVE_BIT  = 2;
  localparam int          CFG_FORMAT_BIT  = 3;

  // Reset values, shift defaults and datapath constants
  localparam logic [11:0] GAIN_RESET      = 12'h800;
  localparam logic [11:0] ZERO_RESET      = 12'h000;
  localparam logic [11:0] INPUT_RESET     = 12'h000;
  localparam logic [11:0] SHIFT_GAIN6     = 12'h99a;
  localparam logic [11:0] SHIFT_GAIN4     = 12'haab;
  localparam logic [12:0] GAIN_BIAS       = 13'h0800;
  localparam logic [11:0] CODE_MAX        = 12'hfff;
  localparam logic [11:0] MSB_FLIP        = 12'h800;

  typedef enum logic [1:0] {
    REG_INPUT,
    REG_GAIN,
    REG_ZERO,
    REG_OTHER
  } dcce_kind_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dcce_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } dcce_apb_rsp_type;

endpackage : dcce_pkg

/* File: rtl/dcce_math.sv */
// Combinational correction datapath: gain multiply, zero add, saturation.
// Assumes straight-binary input and gain, twos-complement zero trim.
`timescale 1ns/10ps
module dcce_math
  import dcce_pkg::*;
(
  input  wire logic [11:0] code_in,
  input  wire logic [11:0] gain_trim,
  input  wire logic [11:0] zero_trim,
  output logic      [11:0] code_out
);

  logic [25:0] product;
  logic [14:0] scaled;
  logic [14:0] sum;

  always_comb begin
    product  = 26'(code_in) * 26'({1'b0, gain_trim} + GAIN_BIAS);
    scaled   = {1'b0, product[25:12]};
    sum      = scaled + 15'(signed'(zero_trim));
    if (sum[14]) begin
      code_out = '0;
    end else if (sum[13:12] != 2'b00) begin
      code_out = CODE_MAX;
    end else begin
      code_out = sum[11:0];
    end
  end

endmodule : dcce_math

/* File: rtl/dcce_arb.sv */
// Fixed-priority picker: lowest pending channel number wins.
// Assumes a binary channel index is wanted with a valid flag.
`timescale 1ns/10ps
module dcce_arb
  import dcce_pkg::*;
(
  input  wire logic [7:0] pending,
  output logic            found,
  output logic [2:0]      index
);

  always_comb begin
    found = 1'b0;
    index = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        index = 3'(i);
      end
    end
  end

endmodule : dcce_arb

/* File: rtl/dcce_top.sv */
// DAC correction engine with APB register access, busy flags and open-drain busy.
// Assumes an APB master on SYS_CLK and a format strap steady while running.
//
// Notes on behaviour
// - Each channel keeps gain and zero trim registers feeding the engine.
// - Result is input times (gain plus 2048) over 4096, plus zero.
// - Writing input, gain or zero trim recomputes that channel while the engine is enabled.
// - Gain trim spans coefficient one half to one and a half.
// - Zero trim spans -2048 to +2047 codes.
// - One engine serves all channels; per-channel pending bits form a register.
// - Pending sets on write, clears when result reaches DAC data.
// - Each correction takes about 500 ns.
// - Channel 0 highest priority, channel 7 lowest; starvation possible.
// - Engine running sets active flag and pulls busy low.
// - Engine disabled: active flag zero, busy pin released.
// - Enable bit resets to zero; off means input copied directly.
// - Engine off: trim writes only store, read back stored values.
// - Reset gives gain 2048, zero 0, input 000h.
// - Group shift default 2458 for gain six, 2731 for gain four.
// - Format strap selects straight binary or twos complement input.
// - Gain trim always straight binary, zero trim always twos complement.
// - Reads return data in the format it was written.
// - Gain select bit chooses amplifier gain six or four.
// - Busy output is open drain, wired with other devices.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module dcce_top
  import dcce_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        DATA_FORMAT_SELECT,
  output logic             BUSY_N_O,
  output logic             BUSY_N_OE,
  output logic             GAIN_SIX,
  output logic             CORRECTION_ENABLE_BIT,
  output logic [95:0]      DAC_DATA_FLAT
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CALC
  } dcce_state_type;

  typedef struct packed {
    dcce_state_type   st;
    logic [4:0]       cnt;
    logic [2:0]       cur;
    logic [7:0]       pend;
    logic [7:0][11:0] input_code;
    logic [7:0][11:0] gain_trim;
    logic [7:0][11:0] zero_trim;
    logic [7:0][11:0] dac_data;
    logic [11:0]      shift_a;
    logic [11:0]      shift_b;
    logic             enable;
    logic             gain_six;
    logic             active;
    logic             fmt;
    dcce_apb_rsp_type rsp;
    logic             busy_oe;
  } dcce_regs_type;

  dcce_regs_type    r_q;
  dcce_regs_type    r_d;
  dcce_apb_req_type req;
  logic             found;
  logic [2:0]       pick;
  logic [11:0]      corr_out;
  logic [11:0]      run_code;

  // Decode the register kind of an address
  function automatic dcce_kind_type kind_of(input logic [11:0] a);
    if (a >= ADDR_INPUT0 && a < ADDR_GAIN0) begin
      kind_of = REG_INPUT;
    end else if (a >= ADDR_GAIN0 && a < ADDR_ZERO0) begin
      kind_of = REG_GAIN;
    end else if (a >= ADDR_ZERO0 && a < ADDR_DACDATA0) begin
      kind_of = REG_ZERO;
    end else begin
      kind_of = REG_OTHER;
    end
  endfunction : kind_of

  // Convert host-format code to straight binary
  function automatic logic [11:0] to_binary(input logic [11:0] c, input logic twos);
    to_binary = twos ? (c ^ MSB_FLIP) : c;
  endfunction : to_binary

  assign req.psel    = PSEL;
  assign req.penable = PENABLE;
  assign req.pwrite  = PWRITE;
  assign req.paddr   = PADDR;
  assign req.pwdata  = PWDATA;

  // Stored input is in host format; engine works in straight binary
  assign run_code = to_binary(r_q.input_code[r_q.cur], r_q.fmt);

  dcce_arb u_arb (
    .pending (r_q.pend),
    .found   (found),
    .index   (pick)
  );

  dcce_math u_math (
    .code_in   (run_code),
    .gain_trim (r_q.gain_trim[r_q.cur]),
    .zero_trim (r_q.zero_trim[r_q.cur]),
    .code_out  (corr_out)
  );

  always_comb begin
    logic          acc;
    logic          wr;
    dcce_kind_type k;
    logic [2:0]    ch;
    logic [11:0]   wv;
    logic [31:0]   rd;
    logic [7:0]    set_mask;
    acc      = 1'b0;
    wr       = 1'b0;
    k        = REG_OTHER;
    ch       = 3'h0;
    wv       = 12'h000;
    rd       = 32'h0000_0000;
    set_mask = 8'h00;
    r_d      = r_q;
    r_d.fmt  = DATA_FORMAT_SELECT;

    acc = req.psel && req.penable && !r_q.rsp.pready;
    wr  = acc && req.pwrite;
    k   = kind_of(req.paddr);
    ch  = req.paddr[4:2];
    wv  = req.pwdata[11:0];

    r_d.rsp.pready  = acc;
    r_d.rsp.pslverr = 1'b0;

    // Register writes
    if (wr) begin
      unique case (k)
        REG_INPUT: begin
          r_d.input_code[ch] = wv;
          if (r_q.enable) begin
            set_mask[ch] = 1'b1;
          end else begin
            r_d.dac_data[ch] = to_binary(wv, r_q.fmt);
          end
        end
        REG_GAIN: begin
          r_d.gain_trim[ch] = wv;
          set_mask[ch]      = r_q.enable;
        end
        REG_ZERO: begin
          r_d.zero_trim[ch] = wv;
          set_mask[ch]      = r_q.enable;
        end
        REG_OTHER: begin
          if (req.paddr == ADDR_CONFIG) begin
            r_d.enable   = req.pwdata[CFG_ENABLE_BIT];
            r_d.gain_six = req.pwdata[CFG_GAIN_BIT];
            if (req.pwdata[CFG_GAIN_BIT] != r_q.gain_six) begin
              r_d.shift_a = req.pwdata[CFG_GAIN_BIT] ? SHIFT_GAIN6 : SHIFT_GAIN4;
              r_d.shift_b = r_d.shift_a;
            end
          end else if (req.paddr == ADDR_SHIFT_A) begin
            r_d.shift_a = wv;
          end else if (req.paddr == ADDR_SHIFT_B) begin
            r_d.shift_b = wv;
          end else if (req.paddr != ADDR_BUSY && !(req.paddr >= ADDR_DACDATA0
                       && req.paddr < ADDR_DACDATA0 + 12'h020)) begin
            r_d.rsp.pslverr = 1'b1;
          end else begin
            r_d.rsp.pslverr = 1'b1;
          end
        end
      endcase
    end

    // Register reads
    if (acc && !req.pwrite) begin
      unique case (k)
        REG_INPUT: rd = {20'h0, r_q.input_code[ch]};
        REG_GAIN:  rd = {20'h0, r_q.gain_trim[ch]};
        REG_ZERO:  rd = {20'h0, r_q.zero_trim[ch]};
        REG_OTHER: begin
          if (req.paddr == ADDR_CONFIG) begin
            rd[CFG_ENABLE_BIT] = r_q.enable;
            rd[CFG_GAIN_BIT]   = r_q.gain_six;
            rd[CFG_ACTIVE_BIT] = r_q.active;
            rd[CFG_FORMAT_BIT] = r_q.fmt;
          end else if (req.paddr == ADDR_BUSY) begin
            rd = {24'h0, r_q.pend};
          end else if (req.paddr == ADDR_SHIFT_A) begin
            rd = {20'h0, r_q.shift_a};
          end else if (req.paddr == ADDR_SHIFT_B) begin
            rd = {20'h0, r_q.shift_b};
          end else if (req.paddr >= ADDR_DACDATA0 && req.paddr < ADDR_DACDATA0 + 12'h020) begin
            rd = {20'h0, r_q.dac_data[ch]};
          end else begin
            r_d.rsp.pslverr = 1'b1;
          end
        end
      endcase
    end
    r_d.rsp.prdata = (acc && !req.pwrite) ? rd : 32'h0000_0000;

    // Correction engine, one shared datapath
    unique case (r_q.st)
      ST_IDLE: begin
        if (r_q.enable && found) begin
          r_d.st  = ST_CALC;
          r_d.cur = pick;
          r_d.cnt = 5'h00;
        end
      end
      ST_CALC: begin
        if (r_q.cnt == CORR_LAST) begin
          r_d.dac_data[r_q.cur] = corr_out;
          r_d.pend[r_q.cur]     = 1'b0;
          r_d.st                = ST_IDLE;
        end else begin
          r_d.cnt = r_q.cnt + 5'h01;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase

    // A new write wins over the completion clear
    r_d.pend = r_d.pend | set_mask;
    if (!r_d.enable) begin
      r_d.pend = 8'h00;
      r_d.st   = ST_IDLE;
    end

    r_d.active  = r_d.enable && (r_d.st == ST_CALC || r_d.pend != 8'h00);
    r_d.busy_oe = r_d.active;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      r_q.st         <= ST_IDLE;
      r_q.cnt        <= 5'h00;
      r_q.cur        <= 3'h0;
      r_q.pend       <= 8'h00;
      r_q.input_code <= {NUM_CH{INPUT_RESET}};
      r_q.gain_trim  <= {NUM_CH{GAIN_RESET}};
      r_q.zero_trim  <= {NUM_CH{ZERO_RESET}};
      r_q.dac_data   <= {NUM_CH{INPUT_RESET}};
      r_q.shift_a    <= SHIFT_GAIN6;
      r_q.shift_b    <= SHIFT_GAIN6;
      r_q.enable     <= 1'b0;
      r_q.gain_six   <= 1'b1;
      r_q.active     <= 1'b0;
      r_q.fmt        <= 1'b0;
      r_q.rsp        <= '0;
      r_q.busy_oe    <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign PRDATA                = r_q.rsp.prdata;
  assign PREADY                = r_q.rsp.pready;
  assign PSLVERR               = r_q.rsp.pslverr;
  assign BUSY_N_O              = 1'b0;
  assign BUSY_N_OE             = r_q.busy_oe;
  assign GAIN_SIX              = r_q.gain_six;
  assign CORRECTION_ENABLE_BIT = r_q.enable;
  assign DAC_DATA_FLAT         = r_q.dac_data;

endmodule : dcce_top

/* File: dv/dcce_asserts.sv */
// Checker for the correction engine top: APB timing, busy pin, DAC data updates.
// Assumes binding onto dcce_top with one clock and synchronous active-low reset.
`timescale 1ns/10ps
module dcce_checker
  import dcce_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        BUSY_N_O,
  input wire logic        BUSY_N_OE,
  input wire logic        GAIN_SIX,
  input wire logic        CORRECTION_ENABLE_BIT,
  input wire logic [95:0] DAC_DATA_FLAT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  a_ready_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_busy_drain_only: assert property (BUSY_N_OE |-> !BUSY_N_O) else $error("busy pin driven high");
  a_busy_off_disabled:
    assert property (!CORRECTION_ENABLE_BIT && !$past(CORRECTION_ENABLE_BIT) |-> !BUSY_N_OE)
    else $error("busy while disabled");
  a_busy_min_time: assert property ($rose(BUSY_N_OE) |=> BUSY_N_OE[*8]) else $error("correction too short");
  a_busy_bounded: assert property ($rose(BUSY_N_OE) |-> ##[1:300] !BUSY_N_OE) else $error("busy stuck");
  a_dac_by_engine:
    assert property ($changed(DAC_DATA_FLAT) && $past(CORRECTION_ENABLE_BIT) |-> $past(BUSY_N_OE))
    else $error("dac data changed outside engine");
  a_dac_bypass_write:
    assert property ($changed(DAC_DATA_FLAT) && !$past(CORRECTION_ENABLE_BIT) |-> $past(PSEL && PENABLE && PWRITE))
    else $error("dac data changed without write");
  a_reset_config: assert property ($rose(RSTN) |-> GAIN_SIX && !CORRECTION_ENABLE_BIT) else $error("bad reset config");
endmodule : dcce_checker

bind dcce_top dcce_checker dcce_checker_inst (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY_N_O(BUSY_N_O), .BUSY_N_OE(BUSY_N_OE),
  .GAIN_SIX(GAIN_SIX), .CORRECTION_ENABLE_BIT(CORRECTION_ENABLE_BIT), .DAC_DATA_FLAT(DAC_DATA_FLAT)
);

/* File: dv/dcce_host_model.sv */
// Host model: APB master tasks and the pulled-up busy wire.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/10ps
module dcce_host_model
  import dcce_pkg::*;
(
  input  wire logic             clk,
  input  wire dcce_apb_rsp_type rsp,
  input  wire logic             busy_oe,
  output dcce_apb_req_type      req,
  output logic                  busy_wire
);
  // Pull-up wins when nobody drains the line
  assign busy_wire = busy_oe ? 1'b0 : 1'b1;

  initial req = '0;

  // Caller spaces channel writes by waiting for idle between rewrites
  // Waits for ready without a limit of its own; the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : xfer
endmodule : dcce_host_model

/* File: dv/test_dac_calibration_correction_engine.sv */
// Self-checking bench for the correction engine top.
// Assumes dcce_host_model as APB master and the bound checker.
`timescale 1ns/10ps
module test_dac_calibration_correction_engine
  import dcce_pkg::*;
;
  logic             sys_clk, rstn, fmt, pready, pslverr, busy_o, busy_oe, gain_six, ena, busy_wire;
  logic [31:0]      prdata;
  logic [95:0]      dac_flat;
  dcce_apb_req_type req;
  dcce_apb_rsp_type rsp;
  int               mismatches, samples_checked;

  assign rsp = '{pready: pready, prdata: prdata, pslverr: pslverr};

  dcce_top dcce_top_inst (
    .SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
    .PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DATA_FORMAT_SELECT(fmt), .BUSY_N_O(busy_o), .BUSY_N_OE(busy_oe), .GAIN_SIX(gain_six),
    .CORRECTION_ENABLE_BIT(ena), .DAC_DATA_FLAT(dac_flat));
  dcce_host_model dcce_host_model_inst (
    .clk(sys_clk), .rsp(rsp), .busy_oe(busy_oe), .req(req), .busy_wire(busy_wire));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic exp_err, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    dcce_host_model_inst.xfer(w, a, d, q, e);
    check("slverr", {31'h0, exp_err}, {31'h0, e});
    if (!w) check($sformatf("read %h", a), exp, q);
  endtask : acc

  function automatic logic [11:0] dac(input int ch);
    return dac_flat[ch*12 +: 12];
  endfunction : dac

  function automatic logic [11:0] corr(input logic [11:0] c, input logic [11:0] g, input logic [11:0] z);
    int t;
    t = ((int'(c) * (int'(g) + 2048)) >>> 12) + int'($signed(z));
    if (t < 0) t = 0;
    if (t > 4095) t = 4095;
    return 12'(t);
  endfunction : corr

  task automatic wait_idle(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (busy_oe !== 1'b0 && n < 400);
    check("idle reached", 1, n < 400);
  endtask : wait_idle

  task automatic t_reset;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      acc(0, ADDR_GAIN0 + 12'(4*ch), 0, 0, {20'h0, GAIN_RESET});
      acc(0, ADDR_ZERO0 + 12'(4*ch), 0, 0, {20'h0, ZERO_RESET});
      acc(0, ADDR_INPUT0 + 12'(4*ch), 0, 0, {20'h0, INPUT_RESET});
    end
    acc(0, ADDR_CONFIG, 0, 0, 32'h2);
    acc(0, ADDR_SHIFT_A, 0, 0, {20'h0, SHIFT_GAIN6});
    acc(0, ADDR_SHIFT_B, 0, 0, {20'h0, SHIFT_GAIN6});
    acc(0, 12'hff0, 0, 1, 0);
    acc(1, ADDR_BUSY, 32'h1, 1, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bypass;
    acc(1, ADDR_INPUT0 + 12'hc, 32'h123, 0, 0);
    @(negedge sys_clk);
    check("dac3 direct", 12'h123, dac(3));
    acc(1, ADDR_GAIN0 + 12'hc, 32'h100, 0, 0);
    acc(1, ADDR_ZERO0 + 12'hc, 32'h5, 0, 0);
    acc(0, ADDR_GAIN0 + 12'hc, 0, 0, 32'h100);
    acc(0, ADDR_ZERO0 + 12'hc, 0, 0, 32'h5);
    check("dac3 kept", 12'h123, dac(3));
    check("busy wire", 1, {busy_oe, busy_wire});
    @(posedge sys_clk);
    fmt <= 1'b1;
    acc(1, ADDR_INPUT0 + 12'h10, 32'h7ff, 0, 0);
    @(negedge sys_clk);
    check("dac4 twos", 12'hfff, dac(4));
    acc(0, ADDR_INPUT0 + 12'h10, 0, 0, 32'h7ff);
    @(posedge sys_clk);
    fmt <= 1'b0;
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_correct;
    int n;
    // Trims loaded with the engine off, so no channel is rewritten while pending
    acc(1, ADDR_GAIN0 + 12'h8, 32'h0, 0, 0);
    acc(1, ADDR_ZERO0 + 12'h8, 32'hff0, 0, 0);
    acc(1, ADDR_GAIN0 + 12'h4, 32'hfff, 0, 0);
    acc(0, ADDR_BUSY, 0, 0, 32'h0);
    acc(1, ADDR_CONFIG, 32'h3, 0, 0);
    acc(1, ADDR_INPUT0 + 12'h8, 32'h100, 0, 0);
    wait_idle(n);
    check("dac2 half gain", corr(12'h100, 12'h0, 12'hff0), dac(2));
    acc(1, ADDR_INPUT0 + 12'h4, 32'hc00, 0, 0);
    wait_idle(n);
    check("dac1 high clamp", corr(12'hc00, 12'hfff, 12'h0), dac(1));
    acc(1, ADDR_ZERO0 + 12'hc, 32'h800, 0, 0);
    wait_idle(n);
    check("dac3 low clamp", corr(12'h123, 12'h100, 12'h800), dac(3));
    acc(1, ADDR_INPUT0, 32'h456, 0, 0);
    wait_idle(n);
    check("latency", CORR_CYCLES + 1, n);
    check("dac0 unity", 12'h456, dac(0));
    acc(1, ADDR_INPUT0, 32'h457, 0, 0);
    acc(0, ADDR_CONFIG, 0, 0, 32'h7);
    wait_idle(n);
    acc(0, ADDR_CONFIG, 0, 0, 32'h3);
    $display("test correct done");
  endtask : t_correct

  task automatic t_priority;
    int t, t0, t5;
    acc(1, ADDR_INPUT0 + 12'h18, 32'h600, 0, 0);
    acc(1, ADDR_INPUT0 + 12'h14, 32'h500, 0, 0);
    acc(1, ADDR_INPUT0, 32'h100, 0, 0);
    acc(0, ADDR_BUSY, 0, 0, 32'h61);
    t = 0;
    t0 = 0;
    t5 = 0;
    while (busy_oe !== 1'b0 && t < 400) begin
      @(posedge sys_clk);
      t++;
      if (t0 == 0 && dac(0) === 12'h100) t0 = t;
      if (t5 == 0 && dac(5) === 12'h500) t5 = t;
    end
    check("ch0 before ch5", 1, t0 > 0 && t0 < t5);
    acc(0, ADDR_BUSY, 0, 0, 32'h0);
    $display("test priority done");
  endtask : t_priority

  task automatic t_gain4;
    int n;
    acc(1, ADDR_CONFIG, 32'h1, 0, 0);
    @(negedge sys_clk);
    check("gain six", 0, gain_six);
    acc(0, ADDR_SHIFT_A, 0, 0, {20'h0, SHIFT_GAIN4});
    acc(0, ADDR_SHIFT_B, 0, 0, {20'h0, SHIFT_GAIN4});
    acc(1, ADDR_CONFIG, 32'h0, 0, 0);
    acc(1, ADDR_INPUT0 + 12'h1c, 32'h777, 0, 0);
    acc(0, ADDR_CONFIG, 0, 0, 32'h0);
    check("dac7 direct", 12'h777, dac(7));
    check("busy wire off", 1, {busy_oe, busy_wire});
    check("enable pin", 0, ena);
    acc(0, ADDR_DACDATA0 + 12'h1c, 0, 0, 32'h777);
    acc(1, ADDR_DACDATA0 + 12'h1c, 32'h1, 1, 0);
    acc(1, ADDR_CONFIG, 32'h3, 0, 0);
    acc(0, ADDR_SHIFT_B, 0, 0, {20'h0, SHIFT_GAIN6});
    acc(1, ADDR_SHIFT_A, 32'h123, 0, 0);
    acc(0, ADDR_SHIFT_A, 0, 0, 32'h123);
    @(posedge sys_clk);
    fmt <= 1'b1;
    acc(1, ADDR_INPUT0 + 12'h1c, 32'h7ff, 0, 0);
    wait_idle(n);
    check("dac7 twos corrected", corr(12'hfff, GAIN_RESET, ZERO_RESET), dac(7));
    acc(0, ADDR_INPUT0 + 12'h1c, 0, 0, 32'h7ff);
    fmt <= 1'b0;
    $display("test gain four done");
  endtask : t_gain4

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim;
  end

  initial begin
    mismatches = 0;
    samples_checked = 0;
    fmt = 1'b0;
    rstn = 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_bypass;
    t_correct;
    t_priority;
    t_gain4;
    end_sim;
  end
endmodule : test_dac_calibration_correction_engine
